// ### rtl/mpt_pkg.sv
/*
  Shared constants for the motor protection trip logic: timing, thresholds,
  fault indices, protection levels and thermal overload budgets.
  Assumes a 250 MHz control clock, currents and voltages scaled in percent, temperature in degrees Celsius.
*/
package mpt_pkg;
  // Clock and millisecond tick
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int MS_TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int TW = 17;

  // Trip delays in milliseconds
  localparam logic [TW-1:0] T_PHASE_MS = 17'h00BB8;
  localparam logic [TW-1:0] T_UNBAL_MS = 17'h00BB8;
  localparam logic [TW-1:0] T_VOLT_HARD_MS = 17'h001F4;
  localparam logic [TW-1:0] T_VOLT_MS = 17'h00BB8;
  localparam logic [TW-1:0] T_SHORT_MS = 17'h00064;
  localparam logic [TW-1:0] T_START_LIGHT_MS = 17'h00BB8;
  localparam logic [TW-1:0] T_START_STD_MS = 17'h03A98;
  localparam logic [TW-1:0] T_START_HEAVY_MS = 17'h07530;
  localparam logic [TW-1:0] T_NONE_MS = 17'h00000;
  localparam logic [TW-1:0] MS_PER_S = 17'h003E8;

  // Temperature hysteresis in degrees Celsius
  localparam logic [7:0] OT_TRIP_C = 8'h50;
  localparam logic [7:0] OT_CLEAR_C = 8'h37;

  // Current and voltage thresholds in percent, start current multipliers, underload delays in seconds
  localparam logic [11:0] LIGHT_LOAD_PCT = 12'h01E;
  localparam logic [11:0] SHORT_PCT = 12'h3E8;
  localparam logic [11:0] START_MULT = 12'h005;
  localparam logic [11:0] ADV_START_MULT = 12'h004;
  localparam logic [7:0] UV_HARD_PCT = 8'h28;
  localparam logic [7:0] OV_HARD_PCT = 8'h8C;
  localparam logic [6:0] UL_THR_MIN = 7'h0A;
  localparam logic [6:0] UL_THR_MAX = 7'h5A;
  localparam logic [6:0] UL_DLY_MIN = 7'h05;
  localparam logic [6:0] UL_DLY_MAX = 7'h5A;

  // Thermal budgets, percent squared times ms, for classes 2, 10, 20
  localparam logic [31:0] K_CLASS2 = 32'h15752A00;
  localparam logic [31:0] K_CLASS10 = 32'h6DAC2C00;
  localparam logic [31:0] K_CLASS20 = 32'hDB585800;
  localparam logic [31:0] HEAT_COOL = 32'h00004E20;

  // Protection levels
  localparam logic [2:0] LVL_PRIMARY = 3'h0;
  localparam logic [2:0] LVL_LIGHT = 3'h1;
  localparam logic [2:0] LVL_STD = 3'h2;
  localparam logic [2:0] LVL_HEAVY = 3'h3;
  localparam logic [2:0] LVL_ADV = 3'h4;

  // Fault indices; the displayed fault code is index plus one
  localparam int NF = 12;
  localparam int FI_OT = 0;
  localparam int FI_PHASE = 1;
  localparam int FI_UNBAL = 2;
  localparam int FI_STARTOC = 3;
  localparam int FI_OVL = 4;
  localparam int FI_UVHARD = 5;
  localparam int FI_UV = 6;
  localparam int FI_OVHARD = 7;
  localparam int FI_OV = 8;
  localparam int FI_SHORT = 9;
  localparam int FI_UNDER = 10;
  localparam int FI_EXT = 11;
  localparam logic [NF-1:0] PRIMARY_MASK = 12'h203;
  localparam logic [4:0] FC_NONE = 5'h00;
endpackage

// ### rtl/mpt_delay_timer.sv
/*
  One fault delay timer counting millisecond ticks while its condition holds.
  Assumes tick is a one-cycle pulse on ref_clk once per millisecond.
*/
`timescale 1ns/1ns
module mpt_delay_timer
  import mpt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic cond,
  input wire logic [TW-1:0] limit,
  output logic expired
);
  typedef struct packed {
    logic [TW-1:0] count;
  } mpt_timer_state_s;

  mpt_timer_state_s st;
  mpt_timer_state_s next_st;

  // Count while the condition holds, restart as soon as it drops
  always_comb begin
    next_st = st;
    if (!cond) begin
      next_st.count = '0;
    end else if (tick && (st.count < limit)) begin
      next_st.count = st.count + 17'h00001;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Expiry only while the condition still stands
  assign expired = cond && (st.count >= limit);

  a_timer_restart: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !cond |=> (st.count == '0))
    else $error("delay timer did not restart");
  a_timer_counts: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cond && tick && (st.count < limit) && $stable(cond) [*1] ##1 cond |-> (st.count == $past(st.count) + 17'h00001))
    else $error("delay timer missed a tick");
endmodule

// ### rtl/mpt_trip_logic.sv
/*
  Protection supervisor of a three-phase soft starter: compares sensed
  temperature, phase currents and supply voltage with limits, times each
  fault and latches the first one into a trip with a fault code.
  Assumes sensor and operator inputs come from outside the clock domain and
  are slow next to the clock; currents are percent of the rated current,
  voltage is percent of nominal, temperature is degrees Celsius.
*/
`timescale 1ns/1ns
// How it works
// - Over-temperature trips at 80 C and holds until 55 C or lower.
// - Phase loss trips within 3 s of detection.
// - Phase deviation above 50 percent trips within 3 s when enabled.
// - Below 30 percent load the unbalance threshold is raised.
// - Start current above 5 times reference trips after the level's time.
// - Running overload uses inverse-time heating scaled to the reference.
// - Undervoltage trips in 0.5 s below 40 percent, 3 s below setting.
// - Overvoltage trips in 0.5 s above 140 percent, 3 s above setting.
// - Current above 10 times rating trips within 0.1 s.
// - Underload below 10 to 90 percent trips after 5 to 90 s.
// - Five protection levels: primary, light, standard, heavy, advanced.
// - Primary ignores external instant stop, keeps heat, short, main circuit.
// - Light, standard, heavy use overload classes 2, 10 and 20.
// - Advanced uses a stricter start check, otherwise standard.
// - Delays run from valid fault detection to the trip.
// - Any trip lights the fault lamp and shows its code.
// - Panel or external stop clears the latched fault once no fault is still expired.
// - Unbalance check enable 0 disables, 1 enables unbalance protection.
module mpt_trip_logic
  import mpt_pkg::*;
#(
  parameter int MS_TICKS = MS_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] heatsinkTemp,
  input wire logic phaseLoss,
  input wire logic [11:0] phaseCurrA,
  input wire logic [11:0] phaseCurrB,
  input wire logic [11:0] phaseCurrC,
  input wire logic [7:0] supplyVolt,
  input wire logic [7:0] underVoltSetting,
  input wire logic [7:0] overVoltSetting,
  input wire logic motorStarting,
  input wire logic motorRunning,
  input wire logic extInstantStop,
  input wire logic panelStop,
  input wire logic extStop,
  input wire logic [2:0] protectionLevelSelect,
  input wire logic [7:0] loadRegulationRate,
  input wire logic unbalanceCheckEnable,
  input wire logic [6:0] underloadThreshold,
  input wire logic [6:0] underloadDelay,
  output logic tripOut,
  output logic faultLed,
  output logic [4:0] faultCodeDisplay
);
  localparam int SW = 100;

  typedef struct packed {
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    logic [17:0] tickCnt;
    logic tick;
    logic overTemp;
    logic [31:0] heat;
    logic trip;
    logic [4:0] code;
  } mpt_trip_state_s;

  mpt_trip_state_s st;
  mpt_trip_state_s next_st;

  logic [SW-1:0] rawIn;
  logic [7:0] tempS;
  logic lossS;
  logic [11:0] curAS;
  logic [11:0] curBS;
  logic [11:0] curCS;
  logic [7:0] voltS;
  logic [7:0] uvSetS;
  logic [7:0] ovSetS;
  logic startS;
  logic runS;
  logic extInstS;
  logic panelStopS;
  logic extStopS;
  logic [2:0] lvlS;
  logic [7:0] refS;
  logic unbalEnS;
  logic [6:0] ulThrS;
  logic [6:0] ulDlyS;

  logic [11:0] maxI;
  logic [11:0] minI;
  logic [13:0] spread;
  logic unbalNom;
  logic unbalRaised;
  logic [11:0] startLimit;
  logic [23:0] iSq;
  logic [23:0] rSq;
  logic [32:0] heatSum;
  logic [31:0] kNow;
  logic [6:0] ulThr;
  logic [6:0] ulDly;
  logic [NF-1:0] rawFault;
  logic [NF-1:0] levelMask;
  logic [NF-1:0] cond;
  logic [NF-1:0] faultNow;
  logic [TW-1:0] lim [NF];
  logic anyFault;
  logic clearReq;
  logic [4:0] firstNow;

  // Lowest index among the asserted faults, as a fault code
  function automatic logic [4:0] first_code(input logic [NF-1:0] v);
    logic [4:0] c;
    c = FC_NONE;
    for (int i = NF - 1; i >= 0; i--) begin
      if (v[i]) begin
        c = 5'(i + 1);
      end
    end
    return c;
  endfunction

  // Thermal budget of the selected level
  function automatic logic [31:0] level_budget(input logic [2:0] lvl);
    logic [31:0] k;
    case (lvl)
      LVL_LIGHT: k = K_CLASS2;
      LVL_HEAVY: k = K_CLASS20;
      default: k = K_CLASS10;
    endcase
    return k;
  endfunction

  // Every pin and setting passes two flip-flops before use
  assign rawIn = {heatsinkTemp, phaseLoss, phaseCurrA, phaseCurrB, phaseCurrC,
                  supplyVolt, underVoltSetting, overVoltSetting, motorStarting,
                  motorRunning, extInstantStop, panelStop, extStop,
                  protectionLevelSelect, loadRegulationRate, unbalanceCheckEnable,
                  underloadThreshold, underloadDelay};
  assign {tempS, lossS, curAS, curBS, curCS, voltS, uvSetS, ovSetS, startS,
          runS, extInstS, panelStopS, extStopS, lvlS, refS, unbalEnS,
          ulThrS, ulDlyS} = st.s2;

  // Largest and smallest phase current
  always_comb begin
    maxI = curAS;
    minI = curAS;
    if (curBS > maxI) begin
      maxI = curBS;
    end
    if (curCS > maxI) begin
      maxI = curCS;
    end
    if (curBS < minI) begin
      minI = curBS;
    end
    if (curCS < minI) begin
      minI = curCS;
    end
  end

  // Unbalance: 50 percent of the peak, 75 percent at light load
  assign spread = {2'b00, maxI - minI};
  assign unbalNom = {spread[12:0], 1'b0} > {2'b00, maxI};
  assign unbalRaised = {spread[11:0], 2'b00} > ({2'b00, maxI} + {1'b0, maxI, 1'b0});

  // Start over-current limit, tighter at the advanced level
  assign startLimit = {4'h0, refS} * ((lvlS == LVL_ADV) ? ADV_START_MULT : START_MULT);

  // Heating terms, squared percent of rated current
  assign iSq = {12'h000, maxI} * {12'h000, maxI};
  assign rSq = {16'h0000, refS} * {16'h0000, refS};
  assign heatSum = {1'b0, st.heat} + {9'h000, iSq - rSq};
  assign kNow = level_budget(lvlS);

  // Underload settings held inside their legal range
  assign ulThr = (ulThrS < UL_THR_MIN) ? UL_THR_MIN : (ulThrS > UL_THR_MAX) ? UL_THR_MAX : ulThrS;
  assign ulDly = (ulDlyS < UL_DLY_MIN) ? UL_DLY_MIN : (ulDlyS > UL_DLY_MAX) ? UL_DLY_MAX : ulDlyS;

  // Raw fault conditions before level gating
  always_comb begin
    rawFault = '0;
    rawFault[FI_OT] = st.overTemp;
    rawFault[FI_PHASE] = lossS;
    rawFault[FI_UNBAL] = (maxI < LIGHT_LOAD_PCT) ? unbalRaised : unbalNom;
    rawFault[FI_STARTOC] = startS && (maxI > startLimit);
    rawFault[FI_OVL] = runS && (st.heat >= kNow);
    rawFault[FI_UVHARD] = voltS < UV_HARD_PCT;
    rawFault[FI_UV] = voltS < uvSetS;
    rawFault[FI_OVHARD] = voltS > OV_HARD_PCT;
    rawFault[FI_OV] = voltS > ovSetS;
    rawFault[FI_SHORT] = maxI > SHORT_PCT;
    rawFault[FI_UNDER] = runS && (maxI < {5'h00, ulThr});
    rawFault[FI_EXT] = extInstS;
  end

  // Level gating: primary keeps heat, short circuit and phase loss only
  always_comb begin
    levelMask = (lvlS == LVL_PRIMARY) ? PRIMARY_MASK : '1;
    levelMask[FI_UNBAL] = levelMask[FI_UNBAL] && unbalEnS;
    cond = rawFault & levelMask;
  end

  // Delay of each fault in milliseconds
  always_comb begin
    for (int i = 0; i < NF; i++) begin
      lim[i] = T_NONE_MS;
    end
    lim[FI_PHASE] = T_PHASE_MS;
    lim[FI_UNBAL] = T_UNBAL_MS;
    case (lvlS)
      LVL_LIGHT: lim[FI_STARTOC] = T_START_LIGHT_MS;
      LVL_HEAVY: lim[FI_STARTOC] = T_START_HEAVY_MS;
      default: lim[FI_STARTOC] = T_START_STD_MS;
    endcase
    lim[FI_UVHARD] = T_VOLT_HARD_MS;
    lim[FI_UV] = T_VOLT_MS;
    lim[FI_OVHARD] = T_VOLT_HARD_MS;
    lim[FI_OV] = T_VOLT_MS;
    lim[FI_SHORT] = T_SHORT_MS;
    lim[FI_UNDER] = 17'({10'h000, ulDly} * MS_PER_S);
  end

  // One delay counter per fault, started by the fault itself
  for (genvar g = 0; g < NF; g++) begin : g_timer
    mpt_delay_timer u_timer (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .tick(st.tick),
      .cond(cond[g]),
      .limit(lim[g]),
      .expired(faultNow[g])
    );
  end

  assign anyFault = |faultNow;
  assign clearReq = panelStopS || extStopS;
  assign firstNow = first_code(faultNow);

  // Next state: sync, tick, hysteresis, heating and the trip latch
  always_comb begin
    next_st = st;
    next_st.s1 = rawIn;
    next_st.s2 = st.s1;
    if (st.tickCnt == 18'(MS_TICKS - 1)) begin
      next_st.tickCnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tickCnt = st.tickCnt + 18'h00001;
      next_st.tick = 1'b0;
    end
    if (tempS >= OT_TRIP_C) begin
      next_st.overTemp = 1'b1;
    end else if (tempS <= OT_CLEAR_C) begin
      next_st.overTemp = 1'b0;
    end
    if (st.tick) begin
      if (runS && (iSq > rSq)) begin
        next_st.heat = heatSum[32] ? '1 : heatSum[31:0];
      end else if (st.heat > HEAT_COOL) begin
        next_st.heat = st.heat - HEAT_COOL;
      end else begin
        next_st.heat = '0;
      end
    end
    // A new fault wins over a stop in the same cycle
    if (anyFault && (!st.trip || clearReq)) begin
      next_st.trip = 1'b1;
      next_st.code = firstNow;
    end else if (clearReq) begin
      next_st.trip = 1'b0;
      next_st.code = FC_NONE;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the latch
  assign tripOut = st.trip;
  assign faultLed = st.trip;
  assign faultCodeDisplay = st.code;

  a_trip_holds: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st.trip && !clearReq |=> st.trip && $stable(st.code))
    else $error("trip released without a stop");
  a_stop_clears: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st.trip && clearReq && !anyFault |=> !tripOut && (faultCodeDisplay == FC_NONE))
    else $error("stop did not clear the trip");
  a_first_code: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !st.trip && anyFault |=> tripOut && (faultCodeDisplay == $past(firstNow)))
    else $error("first fault not latched with its code");
  a_led_code: assert property (@(posedge ref_clk) disable iff (!arst_n)
    faultLed == (faultCodeDisplay != FC_NONE))
    else $error("fault lamp and code disagree");
  a_ot_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tempS >= OT_TRIP_C |=> st.overTemp)
    else $error("over-temperature not raised at trip point");
  a_ot_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st.overTemp && (tempS > OT_CLEAR_C) |=> st.overTemp)
    else $error("over-temperature dropped above release point");
  a_ot_release: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tempS <= OT_CLEAR_C ##1 tempS <= OT_CLEAR_C |-> !st.overTemp)
    else $error("over-temperature held below release point");
  a_level0_gate: assert property (@(posedge ref_clk) disable iff (!arst_n)
    lvlS == LVL_PRIMARY |-> !cond[FI_EXT] && !cond[FI_UNBAL] && !cond[FI_OVL] && !cond[FI_UV])
    else $error("primary level left a gated fault active");
  a_unbal_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !unbalEnS |-> !cond[FI_UNBAL])
    else $error("unbalance active while disabled");
  a_start_time: assert property (@(posedge ref_clk) disable iff (!arst_n)
    lvlS == LVL_HEAVY |-> lim[FI_STARTOC] == T_START_HEAVY_MS)
    else $error("heavy level start delay wrong");
  a_overload_cond: assert property (@(posedge ref_clk) disable iff (!arst_n)
    runS && (st.heat >= kNow) && (lvlS != LVL_PRIMARY) |-> faultNow[FI_OVL])
    else $error("thermal budget spent without overload fault");

  // Heat store, trip latch, short gating, tick and clamp checks
  a_fault_trips: assert property (@(posedge ref_clk) disable iff (!arst_n)
    anyFault |=> tripOut)
    else $error("expired fault did not leave the trip set");
  a_heat_rises: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st.tick && runS && (iSq > rSq) && !heatSum[32] |=> st.heat == $past(st.heat) + $past(iSq) - $past(rSq))
    else $error("heat store did not add the excess heating");
  a_heat_cools: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st.tick && !(runS && (iSq > rSq)) && (st.heat > HEAT_COOL) |=> st.heat == $past(st.heat) - HEAT_COOL)
    else $error("heat store did not cool");
  a_short_kept: assert property (@(posedge ref_clk) disable iff (!arst_n)
    maxI > SHORT_PCT |-> cond[FI_SHORT])
    else $error("short circuit gated off at some level");
  a_tick_single: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (MS_TICKS > 1) && st.tick |=> !st.tick)
    else $error("millisecond tick lasted more than one cycle");
  a_underload_clamped: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (ulThr >= UL_THR_MIN) && (ulThr <= UL_THR_MAX) && (ulDly >= UL_DLY_MIN) && (ulDly <= UL_DLY_MAX))
    else $error("underload setting outside its range");
endmodule

// ### verif/mpt_plant_model.sv
/*
  Plant and operator model for the trip logic: heatsink, phase currents,
  supply, motor state, settings and the two stop buttons.
  Assumes the bench changes these values only just after a falling edge.
*/
`timescale 1ns/1ns
module mpt_plant_model
  import mpt_pkg::*;
(
  input wire logic ref_clk,
  output logic [7:0] heatsinkTemp,
  output logic phaseLoss,
  output logic [11:0] phaseCurrA,
  output logic [11:0] phaseCurrB,
  output logic [11:0] phaseCurrC,
  output logic [7:0] supplyVolt,
  output logic [7:0] underVoltSetting,
  output logic [7:0] overVoltSetting,
  output logic motorStarting,
  output logic motorRunning,
  output logic extInstantStop,
  output logic panelStop,
  output logic extStop,
  output logic [2:0] protectionLevelSelect,
  output logic [7:0] loadRegulationRate,
  output logic unbalanceCheckEnable,
  output logic [6:0] underloadThreshold,
  output logic [6:0] underloadDelay
);
  // Healthy plant: cool heatsink, balanced rated current, nominal supply
  task automatic healthy();
    heatsinkTemp = 8'h19;
    phaseLoss = 1'b0;
    phaseCurrA = 12'h064;
    phaseCurrB = 12'h064;
    phaseCurrC = 12'h064;
    supplyVolt = 8'h64;
    motorStarting = 1'b0;
    motorRunning = 1'b0;
    extInstantStop = 1'b0;
    unbalanceCheckEnable = 1'b1;
    protectionLevelSelect = LVL_STD;
  endtask

  // Operator stop press held a few clocks, then let go
  task automatic press_stop(input logic useExt);
    @(negedge ref_clk);
    if (useExt) begin
      extStop = 1'b1;
    end else begin
      panelStop = 1'b1;
    end
    repeat (4) @(negedge ref_clk);
    panelStop = 1'b0;
    extStop = 1'b0;
  endtask

  // Settings and idle levels from time zero
  initial begin
    healthy();
    panelStop = 1'b0;
    extStop = 1'b0;
    underVoltSetting = 8'h50;
    overVoltSetting = 8'h78;
    loadRegulationRate = 8'h64;
    underloadThreshold = 7'h1E;
    underloadDelay = 7'h05;
  end
endmodule

// ### verif/mpt_trip_logic_tb.sv
/*
  Self-checking bench for the trip logic with a shortened millisecond tick.
  Assumes the plant model drives every design input but clock and reset, and the bench commands
  it through its variables and tasks after falling edges.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module mpt_trip_logic_tb
  import mpt_pkg::*;
;
  localparam int MT = 2;
  int n_mismatch = 0;
  int compares = 0;
  logic ref_clk;
  logic arst_n;
  logic [7:0] heatsinkTemp, supplyVolt, underVoltSetting, overVoltSetting, loadRegulationRate;
  logic [11:0] phaseCurrA, phaseCurrB, phaseCurrC;
  logic phaseLoss, motorStarting, motorRunning, extInstantStop, panelStop, extStop;
  logic [2:0] protectionLevelSelect;
  logic unbalanceCheckEnable;
  logic [6:0] underloadThreshold, underloadDelay;
  logic tripOut, faultLed;
  logic [4:0] faultCodeDisplay;

  // Plant on the far side and the block under test
  mpt_plant_model pm (.ref_clk, .heatsinkTemp, .phaseLoss, .phaseCurrA, .phaseCurrB, .phaseCurrC,
    .supplyVolt, .underVoltSetting, .overVoltSetting, .motorStarting, .motorRunning, .extInstantStop,
    .panelStop, .extStop, .protectionLevelSelect, .loadRegulationRate, .unbalanceCheckEnable,
    .underloadThreshold, .underloadDelay);
  mpt_trip_logic #(.MS_TICKS(MT)) uut (.ref_clk, .arst_n, .heatsinkTemp, .phaseLoss, .phaseCurrA,
    .phaseCurrB, .phaseCurrC, .supplyVolt, .underVoltSetting, .overVoltSetting, .motorStarting,
    .motorRunning, .extInstantStop, .panelStop, .extStop, .protectionLevelSelect, .loadRegulationRate,
    .unbalanceCheckEnable, .underloadThreshold, .underloadDelay, .tripOut, .faultLed, .faultCodeDisplay);

  // Clock at 250 MHz
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Counts, verdict and end of run
  task automatic finish_test();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic set_curr(input logic [11:0] a, input logic [11:0] b, input logic [11:0] c);
    pm.phaseCurrA = a;
    pm.phaseCurrB = b;
    pm.phaseCurrC = c;
  endtask

  // Waits for the trip and judges its moment, code and lamp
  task automatic expect_trip(input int lo, input int hi, input logic [4:0] code);
    int n;
    n = 0;
    while (tripOut !== 1'b1 && n < hi) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("tripTime", 1'b1, n >= lo && n < hi)
    `CHK("faultCode", code, faultCodeDisplay)
    `CHK("faultLed", 1'b1, faultLed)
  endtask

  // Removes the fault, presses a stop and expects a clean state
  task automatic clear(input logic useExt);
    pm.healthy();
    repeat (4) @(negedge ref_clk);
    pm.press_stop(useExt);
    repeat (6) @(negedge ref_clk);
    `CHK("clearTrip", 1'b0, tripOut)
    `CHK("clearCode", FC_NONE, faultCodeDisplay)
  endtask

  // Set point, then hysteresis band that a stop cannot clear
  task automatic t_overtemp();
    pm.heatsinkTemp = 8'h4F;
    repeat (40) @(negedge ref_clk);
    `CHK("tempBelow", 1'b0, tripOut)
    pm.heatsinkTemp = 8'h50;
    expect_trip(0, 10, 5'h01);
    pm.heatsinkTemp = 8'h38;
    pm.press_stop(1'b0);
    repeat (8) @(negedge ref_clk);
    `CHK("tempHyst", 1'b1, tripOut)
    clear(1'b1);
  endtask

  // Deep undervoltage dropped early, then held; a later fault keeps the code
  task automatic t_restart();
    pm.supplyVolt = 8'h20;
    repeat (400 * MT) @(negedge ref_clk);
    pm.supplyVolt = 8'h64;
    repeat (8) @(negedge ref_clk);
    `CHK("uvEarly", 1'b0, tripOut)
    pm.supplyVolt = 8'h20;
    expect_trip(499 * MT, 500 * MT + 8, 5'h06);
    set_curr(12'h3E9, 12'h064, 12'h064);
    repeat (300 * MT) @(negedge ref_clk);
    `CHK("firstFault", 5'h06, faultCodeDisplay)
    clear(1'b0);
  endtask

  // Timed faults from a table of codes and delays in ms
  task automatic t_timed();
    int cd[5] = '{2, 8, 9, 10, 11};
    int ms[5] = '{3000, 500, 3000, 100, 5000};
    for (int i = 0; i < 5; i++) begin
      case (cd[i])
        2: pm.phaseLoss = 1'b1;
        8: pm.supplyVolt = 8'h8D;
        9: pm.supplyVolt = 8'h7D;
        10: set_curr(12'h3E9, 12'h3E9, 12'h3E9);
        default: begin
          pm.motorRunning = 1'b1;
          set_curr(12'h014, 12'h014, 12'h014);
        end
      endcase
      expect_trip((ms[i] - 1) * MT, ms[i] * MT + 8, 5'(cd[i]));
      clear(i[0]);
    end
  endtask

  // Unbalance off, then on, then below the light-load point
  task automatic t_unbal();
    pm.unbalanceCheckEnable = 1'b0;
    pm.phaseCurrC = 12'h028;
    repeat (3000 * MT + 40) @(negedge ref_clk);
    `CHK("unbalOff", 1'b0, tripOut)
    pm.unbalanceCheckEnable = 1'b1;
    expect_trip(2999 * MT, 3000 * MT + 8, 5'h03);
    clear(1'b1);
    set_curr(12'h014, 12'h014, 12'h008);
    repeat (3000 * MT + 40) @(negedge ref_clk);
    `CHK("unbalLight", 1'b0, tripOut)
    pm.healthy();
  endtask

  // Primary level drops stop and voltage faults; every other level trips
  task automatic t_levels();
    pm.protectionLevelSelect = LVL_PRIMARY;
    pm.extInstantStop = 1'b1;
    pm.supplyVolt = 8'h20;
    repeat (600 * MT) @(negedge ref_clk);
    `CHK("primaryIgnore", 1'b0, tripOut)
    pm.supplyVolt = 8'h64;
    set_curr(12'h3E9, 12'h3E9, 12'h3E9);
    expect_trip(99 * MT, 100 * MT + 8, 5'h0A);
    clear(1'b0);
    for (int l = 1; l < 5; l++) begin
      pm.protectionLevelSelect = 3'(l);
      pm.extInstantStop = 1'b1;
      expect_trip(0, 10, 5'h0C);
      clear(1'b0);
    end
  endtask

  // Start current at five times the reference holds, just above it trips at light level
  task automatic t_start();
    pm.protectionLevelSelect = LVL_LIGHT;
    pm.motorStarting = 1'b1;
    set_curr(12'h1F4, 12'h1F4, 12'h1F4);
    repeat (3000 * MT + 40) @(negedge ref_clk);
    `CHK("startAtLimit", 1'b0, tripOut)
    set_curr(12'h1F5, 12'h1F5, 12'h1F5);
    expect_trip(2999 * MT, 3000 * MT + 8, 5'h04);
    clear(1'b1);
  endtask

  // Running at three times rated current, class 2 curve trips after 4.5 s
  task automatic t_overload();
    pm.protectionLevelSelect = LVL_LIGHT;
    pm.motorRunning = 1'b1;
    set_curr(12'h12C, 12'h12C, 12'h12C);
    expect_trip(4499 * MT, 4500 * MT + 8, 5'h05);
    clear(1'b0);
  endtask

  // Reset, then the scenarios in turn
  initial begin
    arst_n = 1'b0;
    repeat (19) @(negedge ref_clk);
    `CHK("resetTrip", 1'b0, tripOut)
    `CHK("resetCode", FC_NONE, faultCodeDisplay)
    @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_overtemp();
    t_restart();
    t_timed();
    t_unbal();
    t_levels();
    t_start();
    t_overload();
    finish_test();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end
endmodule
